/* File: common/dac_channel_pkg.sv */
// package: register map, field layout and encodings of the converter channel
package dac_channel_pkg;
   localparam logic [7:0] addr_config_main = 8'h95;
   localparam logic [7:0] addr_config_gain = 8'h96;
   localparam logic [7:0] addr_data_low    = 8'h8b;
   localparam logic [7:0] addr_data_high   = 8'h8c;

   localparam logic [7:0] reset_data_low    = 8'h00;
   localparam logic [7:0] reset_data_high   = 8'h00;
   localparam logic [1:0] reset_buffer_gain = 2'h1;
   localparam logic [2:0] reset_update_src  = 3'h0;
   localparam logic       reset_justify     = 1'b0;
   localparam logic       reset_inhibit     = 1'b0;
   localparam logic       reset_pulse       = 1'b0;
   localparam logic [7:0] reset_rdata       = 8'h00;

   localparam int cfg_justify_pos = 5;
   localparam int cfg_src_msb     = 2;
   localparam int gain_msb        = 1;
   localparam int data_width      = 12;

   localparam logic [data_width-1:0] reset_code = 12'h000;

   typedef enum logic [2:0] {
      every_clock_source  = 3'b000,
      timer_three_overflow = 3'b001,
      timer_four_overflow  = 3'b010,
      timer_five_overflow  = 3'b011,
      logic_output_zero    = 3'b100,
      logic_output_one     = 3'b101,
      logic_output_two     = 3'b110,
      logic_output_three   = 3'b111
   } update_src_e;

   typedef enum logic [1:0] {
      gain_two            = 2'b00,
      gain_two_point_four = 2'b01,
      gain_three          = 2'b10
   } buffer_gain_e;

   // register write/read port from the core
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   // trigger inputs: timer overflows and logic outputs
   typedef struct packed {
      logic [2:0] timer_overflow;
      logic [3:0] logic_output;
   } trig_in_s;
endpackage : dac_channel_pkg

/* File: core/dac_edge_detect.sv */
// rising-edge detector with two-stage synchroniser for one trigger input
`timescale 1ns/1ns
`default_nettype none
module dac_edge_detect (
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic clk_en,
   input  wire logic async_in,
   output logic      rise
);
   logic meta;
   logic sync;
   logic last;
   logic next_meta;
   logic next_sync;
   logic next_last;

   always_comb begin
      next_meta = meta;
      next_sync = sync;
      next_last = last;
      if (clk_en) begin
         next_meta = async_in;
         next_sync = meta;
         next_last = sync;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         meta <= 1'b0;
         sync <= 1'b0;
         last <= 1'b0;
      end else begin
         meta <= next_meta;
         sync <= next_sync;
         last <= next_last;
      end
   end

   // the second stage and its one-cycle delayed copy feed the edge compare
   assign rise = sync & ~last;
endmodule // dac_edge_detect
`default_nettype wire

/* File: core/dac_channel_update_control.sv */
// converter channel: data latch, update trigger select, gain and justification
// Functional notes
// - source code 0 updates every clock; codes 1-3 on timer 3/4/5 overflow
// - codes 4-7 update on rising edge of logic outputs 0-3
// - low-byte write blocks updates; high-byte write releases the block
// - low-byte data register, 8-bit read-write, resets to 0x00
// - 2-bit buffer gain, reset 0x1, codes 2/2.4/3, driven to buffer
// - high-byte data register, 8-bit read-write, resets to 0x00
`timescale 1ns/1ns
`default_nettype none
module dac_channel_update_control
   import dac_channel_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  resetn,
   input  wire logic                  clk_en,
   input  wire reg_req_s              reg_req,
   input  wire trig_in_s              trig_in,
   output logic [7:0]                 reg_rdata,
   output logic [data_width-1:0]      converter_code,
   output logic                       update_pulse,
   output logic [1:0]                 buffer_gain_select
);
   logic [7:0]            data_low;
   logic [7:0]            data_high;
   logic [2:0]            update_src;
   logic                  justify_select;
   logic                  inhibit;
   logic [data_width-1:0] next_code;
   logic [7:0]            next_data_low;
   logic [7:0]            next_data_high;
   logic [2:0]            next_update_src;
   logic                  next_justify;
   logic                  next_inhibit;
   logic [1:0]            next_gain;
   logic [7:0]            next_rdata;
   logic                  next_pulse;
   logic [3:0]            logic_rise;
   logic [2:0]            timer_sync1;
   logic [2:0]            timer_sync2;
   logic                  trigger;
   logic [data_width-1:0] word;
   logic [2:0]            next_timer_sync1;
   logic [2:0]            next_timer_sync2;
   logic                  wr_low;
   logic                  wr_high;
   logic                  wr_main;
   logic                  wr_gain;
   logic                  rd_take;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_edge
         dac_edge_detect u_edge (
            .clk_sys  (clk_sys),
            .resetn   (resetn),
            .clk_en   (clk_en),
            .async_in (trig_in.logic_output[gi]),
            .rise     (logic_rise[gi])
         );
      end
   endgenerate

   // two flops so timer and logic-output triggers share one latency
   always_comb begin
      next_timer_sync1 = timer_sync1;
      next_timer_sync2 = timer_sync2;
      if (clk_en) begin
         next_timer_sync1 = trig_in.timer_overflow;
         next_timer_sync2 = timer_sync1;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         timer_sync1 <= 3'h0;
         timer_sync2 <= 3'h0;
      end else begin
         timer_sync1 <= next_timer_sync1;
         timer_sync2 <= next_timer_sync2;
      end
   end

   always_comb begin
      unique case (update_src_e'(update_src))
         every_clock_source:   trigger = 1'b1;
         timer_three_overflow: trigger = timer_sync2[0];
         timer_four_overflow:  trigger = timer_sync2[1];
         timer_five_overflow:  trigger = timer_sync2[2];
         logic_output_zero:    trigger = logic_rise[0];
         logic_output_one:     trigger = logic_rise[1];
         logic_output_two:     trigger = logic_rise[2];
         logic_output_three:   trigger = logic_rise[3];
      endcase
   end

   always_comb begin
      if (justify_select) begin
         word = {data_high, data_low[7:4]};
      end else begin
         word = {data_high[3:0], data_low};
      end
   end

   // decoded strobes; a frozen cycle takes no access
   always_comb begin
      wr_low  = clk_en && reg_req.wr && (reg_req.addr == addr_data_low);
      wr_high = clk_en && reg_req.wr && (reg_req.addr == addr_data_high);
      wr_main = clk_en && reg_req.wr && (reg_req.addr == addr_config_main);
      wr_gain = clk_en && reg_req.wr && (reg_req.addr == addr_config_gain);
      rd_take = clk_en && reg_req.rd;
   end

   always_comb begin
      next_data_low  = data_low;
      next_data_high = data_high;
      if (wr_low) begin
         next_data_low = reg_req.wdata;
      end
      if (wr_high) begin
         next_data_high = reg_req.wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         data_low  <= reset_data_low;
         data_high <= reset_data_high;
      end else begin
         data_low  <= next_data_low;
         data_high <= next_data_high;
      end
   end

   // low write blocks, high write releases
   always_comb begin
      next_inhibit = inhibit;
      if (wr_low) begin
         next_inhibit = 1'b1;
      end else if (wr_high) begin
         next_inhibit = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         inhibit <= reset_inhibit;
      end else begin
         inhibit <= next_inhibit;
      end
   end

   // reserved and unbuilt bits are dropped on write
   always_comb begin
      next_justify    = justify_select;
      next_update_src = update_src;
      next_gain       = buffer_gain_select;
      if (wr_main) begin
         next_justify    = reg_req.wdata[cfg_justify_pos];
         next_update_src = reg_req.wdata[cfg_src_msb:0];
      end
      if (wr_gain) begin
         next_gain = reg_req.wdata[gain_msb:0];
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         update_src         <= reset_update_src;
         justify_select     <= reset_justify;
         buffer_gain_select <= reset_buffer_gain;
      end else begin
         update_src         <= next_update_src;
         justify_select     <= next_justify;
         buffer_gain_select <= next_gain;
      end
   end

   // pulse holds through a frozen cycle like all state
   always_comb begin
      next_code  = converter_code;
      next_pulse = update_pulse;
      if (clk_en) begin
         next_pulse = 1'b0;
         if (trigger && !inhibit) begin
            next_code  = word;
            next_pulse = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         converter_code <= reset_code;
         update_pulse   <= reset_pulse;
      end else begin
         converter_code <= next_code;
         update_pulse   <= next_pulse;
      end
   end

   // unmapped addresses read as zero
   always_comb begin
      next_rdata = reg_rdata;
      if (rd_take) begin
         unique case (reg_req.addr)
            addr_data_low:    next_rdata = data_low;
            addr_data_high:   next_rdata = data_high;
            addr_config_main: next_rdata = {2'h0, justify_select, 2'h0, update_src};
            addr_config_gain: next_rdata = {6'h00, buffer_gain_select};
            default:          next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= reset_rdata;
      end else begin
         reg_rdata <= next_rdata;
      end
   end
endmodule // dac_channel_update_control
`default_nettype wire

/* File: tb/dac_update_sva.sv */
// checker: port-level properties of the converter channel
`timescale 1ns/1ns
`default_nettype none
module dac_update_sva
   import dac_channel_pkg::*;
(
   input wire logic                  clk_sys,
   input wire logic                  resetn,
   input wire logic                  clk_en,
   input wire reg_req_s              reg_req,
   input wire trig_in_s              trig_in,
   input wire logic [7:0]            reg_rdata,
   input wire logic [data_width-1:0] converter_code,
   input wire logic                  update_pulse,
   input wire logic [1:0]            buffer_gain_select
);
   logic [7:0] lo, hi, cm;
   logic       inh;
   // shadow state moves on the same edge as the block
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         {lo, hi, cm, inh} <= '0;
      end else if (clk_en && reg_req.wr) begin
         if (reg_req.addr == addr_data_low) {lo, inh} <= {reg_req.wdata, 1'b1};
         if (reg_req.addr == addr_data_high) {hi, inh} <= {reg_req.wdata, 1'b0};
         if (reg_req.addr == addr_config_main) cm <= reg_req.wdata;
      end
   end
   wire logic [data_width-1:0] word = cm[cfg_justify_pos] ? {hi, lo[7:4]} : {hi[3:0], lo};
   default clocking @(posedge clk_sys); endclocking
   // frozen cycles hold stale pulses, so skip them
   default disable iff (!resetn || !clk_en);
   sequence s_tmr;
      (cm[2:0] inside {3'h1, 3'h2, 3'h3}) && trig_in.timer_overflow[cm[1:0] - 2'h1];
   endsequence
   sequence s_rise; cm[2] && $rose(trig_in.logic_output[cm[1:0]]); endsequence
   property p_every; !inh && cm[2:0] == 3'h0 |=> update_pulse; endproperty
   a_every: assert property (p_every) else $error("missed clock update");
   property p_tmr; s_tmr ##2 !inh |=> update_pulse; endproperty
   a_tmr: assert property (p_tmr) else $error("missed timer update");
   property p_rise; s_rise ##2 !inh |=> update_pulse; endproperty
   a_rise: assert property (p_rise) else $error("missed edge update");
   property p_block; update_pulse |-> !$past(inh); endproperty
   a_block: assert property (p_block) else $error("update while blocked");
   property p_hold; !update_pulse |-> $stable(converter_code); endproperty
   a_hold: assert property (p_hold) else $error("code moved without update");
   property p_code; update_pulse |-> converter_code == $past(word); endproperty
   a_code: assert property (p_code) else $error("wrong word loaded");
   property p_lo; reg_req.rd && reg_req.addr == addr_data_low |=> reg_rdata == $past(lo); endproperty
   a_lo: assert property (p_lo) else $error("low byte readback");
   property p_hi; reg_req.rd && reg_req.addr == addr_data_high |=> reg_rdata == $past(hi); endproperty
   a_hi: assert property (p_hi) else $error("high byte readback");
   property p_gain;
      reg_req.wr && reg_req.addr == addr_config_gain |=> buffer_gain_select == $past(reg_req.wdata[1:0]);
   endproperty
   a_gain: assert property (p_gain) else $error("gain not driven");
endmodule // dac_update_sva
`default_nettype wire

/* File: tb/tb_dac_channel_update_control.sv */
// testbench: register-level scenarios for the converter channel
`timescale 1ns/1ns
`default_nettype none
module tb_dac_channel_update_control;
   import dac_channel_pkg::*;
   logic                  clk_sys = 1'b0;
   logic                  resetn = 1'b0;
   logic                  en = 1'b1;
   reg_req_s              rq = '0;
   trig_in_s              tg = '0;
   logic [7:0]            reg_rdata;
   logic [data_width-1:0] converter_code, prev;
   logic                  update_pulse;
   logic [1:0]            buffer_gain_select;
   int                    err_count = 0;
   int                    num_checks = 0;
   int                    cyc = 0;
   always #5 clk_sys = ~clk_sys;
   dac_channel_update_control dac_channel_update_control_inst (
      .clk_sys(clk_sys), .resetn(resetn), .clk_en(en), .reg_req(rq), .trig_in(tg),
      .reg_rdata(reg_rdata), .converter_code(converter_code), .update_pulse(update_pulse),
      .buffer_gain_select(buffer_gain_select));
   task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      rq = '{1'b1, 1'b0, a, d};
      @(negedge clk_sys);
      rq = '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
      @(negedge clk_sys);
      rq = '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk_sys);
      rq = '0;
      chk(n, {4'h0, e}, {4'h0, reg_rdata});
   endtask
   task automatic load(input logic [7:0] l, input logic [7:0] h);
      wr(addr_data_low, l);
      wr(addr_data_high, h);
   endtask
   task automatic report_and_stop();
      if (err_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // whole run needs under two hundred cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         report_and_stop();
      end
   end
   initial begin
      step(16);
      resetn = 1'b1;
      chk("gain", 12'h1, {10'h0, buffer_gain_select});
      rd(addr_data_low, 8'h00, "low");
      rd(addr_data_high, 8'h00, "high");
      rd(addr_config_gain, 8'h01, "cfg_gain");
      for (int g = 0; g < 3; g++) begin
         wr(addr_config_gain, 8'(g));
         chk("gain", 12'(g), {10'h0, buffer_gain_select});
      end
      load(8'ha5, 8'h3c);
      step(4);
      chk("code", 12'hca5, converter_code);
      chk("pulse", 12'h1, {11'h0, update_pulse});
      // frozen enable: the write must be ignored
      en = 1'b0;
      wr(addr_data_low, 8'h77);
      en = 1'b1;
      rd(addr_data_low, 8'ha5, "frozen_low");
      wr(addr_config_main, 8'h20);
      load(8'h5a, 8'hb7);
      step(4);
      chk("code", 12'hb75, converter_code);
      rd(addr_data_low, 8'h5a, "low");
      rd(addr_data_high, 8'hb7, "high");
      wr(addr_data_low, 8'h00);
      step(4);
      chk("code", 12'hb75, converter_code);
      chk("pulse", 12'h0, {11'h0, update_pulse});
      wr(addr_data_high, 8'hff);
      step(4);
      chk("code", 12'hff0, converter_code);
      prev = 12'hff0;
      for (int s = 1; s < 8; s++) begin
         wr(addr_config_main, 8'(s));
         load(8'(s * 17), 8'(s));
         step(4);
         chk("code", prev, converter_code);
         chk("pulse", 12'h0, {11'h0, update_pulse});
         @(negedge clk_sys);
         if (s < 4) tg.timer_overflow[s-1] = 1'b1;
         else tg.logic_output[s-4] = 1'b1;
         @(negedge clk_sys);
         tg.timer_overflow = '0;
         step(5);
         prev = {4'(s), 8'(s * 17)};
         chk("code", prev, converter_code);
         tg.logic_output = '0;
      end
      report_and_stop();
   end
endmodule // tb_dac_channel_update_control
bind dac_channel_update_control dac_update_sva dac_update_sva_inst (
   .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .reg_req(reg_req), .trig_in(trig_in),
   .reg_rdata(reg_rdata), .converter_code(converter_code), .update_pulse(update_pulse),
   .buffer_gain_select(buffer_gain_select));
`default_nettype wire
